// ---- verilog/bkreg_pkg.sv ----
// package: constants and register map for the buck regulator control block
package bkreg_pkg;
  localparam int          NUM_CH          = 3;
  localparam int          CODE_W          = 6;
  localparam int          ADDR_W          = 12;
  // register byte offsets; each channel occupies a 16-byte window
  localparam logic [11:0] CH_STRIDE       = 12'h010;
  localparam logic [11:0] OFS_CTRL        = 12'h000;
  localparam logic [11:0] OFS_PRIMARY     = 12'h004;
  localparam logic [11:0] OFS_ALTERNATE   = 12'h008;
  localparam logic [11:0] OFS_STATUS      = 12'h00c;
  localparam logic [11:0] OFS_IRQ_STATUS  = 12'h040;
  localparam logic [11:0] OFS_IRQ_MASK    = 12'h044;
  localparam logic [11:0] OFS_PB_ASSIGN   = 12'h048;
  // ctrl register fields
  localparam int          BIT_ENABLE      = 0;
  localparam int          BIT_RANGE       = 6;
  // status register fields
  localparam int          BIT_POWER_OK    = 0;
  localparam int          BIT_ACTIVE      = 1;
  localparam int          BIT_RAMP_DONE   = 2;
  // interrupt status layout: [2:0] power-ok lost, [5:3] ramp done
  localparam int          IRQ_W           = 6;
  localparam int          IRQ_DONE_BASE   = 3;
  // reset values
  localparam logic [5:0]  DEFAULT_CODE    = 6'h39;
  localparam logic        DEFAULT_RANGE   = 1'b0;
  localparam logic        DEFAULT_ENABLE  = 1'b1;
  localparam logic [2:0]  DEFAULT_PB      = 3'h0;
  // soft-start ramp time and derived cycle count at 100 MHz
  localparam int          CLK_MHZ         = 100;
  localparam int          SOFT_START_US   = 80;
  localparam int          SOFT_START_CYC  = SOFT_START_US * CLK_MHZ;
  localparam int          RAMP_W          = 14;
  localparam int          SYNC_W          = 2;
endpackage

// ---- verilog/bkreg_channel.sv ----
// file: one converter channel: enable decision, soft-start timer and power-ok tracking
`timescale 1ns/1ps
module bkreg_channel
  import bkreg_pkg::*;
#(
  parameter logic [RAMP_W-1:0] RAMP_CYC = RAMP_W'(SOFT_START_CYC)
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic pin_en_i,
  input  wire logic bit_en_i,
  input  wire logic pb_req_i,
  input  wire logic out_ok_i,
  output logic      active_o,
  output logic      ramp_done_o,
  output logic      power_ok_o,
  output logic      ok_lost_o,
  output logic      done_evt_o
);
  typedef struct packed {
    logic              active;
    logic              done;
    logic              ok;
    logic              lost;
    logic              done_evt;
    logic [RAMP_W-1:0] cnt;
  } bkreg_ch_s;

  bkreg_ch_s ch_reg;
  bkreg_ch_s ch_next;
  logic      want;

  always_comb begin
    // enabled by pin+bit, or by pushbutton if assigned; else off
    want = (pin_en_i & bit_en_i) | pb_req_i;
    ch_next          = ch_reg;
    ch_next.lost     = 1'b0;
    ch_next.done_evt = 1'b0;
    ch_next.active   = want;
    if (!want) begin
      ch_next.cnt  = '0;
      ch_next.done = 1'b0;
    end else if (!ch_reg.done) begin
      // ramp length fixed, does not depend on load
      if (ch_reg.cnt == RAMP_CYC - 1'b1) begin
        ch_next.done     = 1'b1;
        ch_next.done_evt = 1'b1;
      end else begin
        ch_next.cnt = ch_reg.cnt + 1'b1;
      end
    end
    // ok flag only meaningful after ramp; drops as soon as comparator trips
    ch_next.ok = ch_reg.done & want & out_ok_i;
    if (ch_reg.ok && !ch_next.ok) begin
      ch_next.lost = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ch_reg <= '0;
    end else begin
      ch_reg <= ch_next;
    end
  end

  assign active_o    = ch_reg.active;
  assign ramp_done_o = ch_reg.done;
  assign power_ok_o  = ch_reg.ok;
  assign ok_lost_o   = ch_reg.lost;
  assign done_evt_o  = ch_reg.done_evt;
endmodule

// ---- verilog/bkreg_top.sv ----
// file: top of buck regulator control: apb registers, pin sync, setpoint select, channels
//
// Overview of operation
// - A channel turns on when its enable pin is high and its enable bit is one.
// - A channel may also turn on while the pushbutton is held low if it is assigned to it.
// - With no enabling condition a channel stays off.
// - The power-ok flag goes to zero whenever the output drops below its good threshold.
// - On enable the output follows a fixed 80 us soft-start ramp independent of load.
// - After reset both voltage codes of each channel hold the same default setpoint.
// - The select pin low picks every primary code, high picks every alternate code.
// - Codes and range bits of each channel are written independently over the bus.
`timescale 1ns/1ps
module bkreg_top
  import bkreg_pkg::*;
#(
  parameter logic [RAMP_W-1:0] RAMP_CYC = RAMP_W'(SOFT_START_CYC)
) (
  input  wire logic                        CLK_I,
  input  wire logic                        RST_B_I,
  input  wire logic                        PSEL_I,
  input  wire logic                        PENABLE_I,
  input  wire logic                        PWRITE_I,
  input  wire logic [bkreg_pkg::ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]                 PWDATA_I,
  input  wire logic [3:0]                  PSTRB_I,
  output logic [31:0]                      PRDATA_O,
  output logic                             PREADY_O,
  output logic                             PSLVERR_O,
  input  wire logic [bkreg_pkg::NUM_CH-1:0] REGULATOR_ENABLE_PIN_I,
  input  wire logic                        PUSHBUTTON_INPUT_N_I,
  input  wire logic                        VOLTAGE_SET_SELECT_PIN_I,
  input  wire logic [bkreg_pkg::NUM_CH-1:0] OUTPUT_GOOD_I,
  output logic [bkreg_pkg::NUM_CH-1:0]      CONVERTER_ENABLE_O,
  output logic [bkreg_pkg::NUM_CH-1:0]      VOLTAGE_RANGE_O,
  output logic [bkreg_pkg::NUM_CH*bkreg_pkg::CODE_W-1:0] VOLTAGE_CODE_O,
  output logic [bkreg_pkg::NUM_CH-1:0]      POWER_OK_O,
  output logic                             IRQ_O
);
  import bkreg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [NUM_CH-1:0]             en_bit;
    logic [NUM_CH-1:0]             range;
    logic [NUM_CH-1:0][CODE_W-1:0] prim;
    logic [NUM_CH-1:0][CODE_W-1:0] alt;
    logic [NUM_CH-1:0][CODE_W-1:0] code_out;
    logic [NUM_CH-1:0]             range_out;
    logic [NUM_CH-1:0]             pb_assign;
    logic [IRQ_W-1:0]              irq_stat;
    logic [IRQ_W-1:0]              irq_mask;
    logic [31:0]                   rdata;
    logic                          slverr;
    logic [SYNC_W-1:0][NUM_CH-1:0] en_sync;
    logic [SYNC_W-1:0]             pb_sync;
    logic [SYNC_W-1:0]             sel_sync;
    logic [SYNC_W-1:0][NUM_CH-1:0] good_sync;
  } bkreg_top_s;

  bkreg_top_s st_reg;
  bkreg_top_s st_next;

  logic [NUM_CH-1:0] ch_active;
  logic [NUM_CH-1:0] ch_done;
  logic [NUM_CH-1:0] ch_ok;
  logic [NUM_CH-1:0] ch_lost;
  logic [NUM_CH-1:0] ch_done_evt;
  logic [NUM_CH-1:0] pb_req;
  logic              pb_pressed;

  // the pushbutton is active low; request goes only to assigned channels
  assign pb_pressed = ~st_reg.pb_sync[1];
  assign pb_req     = st_reg.pb_assign & {NUM_CH{pb_pressed}};

  ////////////////////////////////////////////////////////////////////////////
  // channels: each owns its own ramp and ok state
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gen_ch
      bkreg_channel #(
        .RAMP_CYC (RAMP_CYC)
      ) u_ch (
        .clk_i       (CLK_I),
        .rst_b_i     (RST_B_I),
        .pin_en_i    (st_reg.en_sync[1][g]),
        .bit_en_i    (st_reg.en_bit[g]),
        .pb_req_i    (pb_req[g]),
        .out_ok_i    (st_reg.good_sync[1][g]),
        .active_o    (ch_active[g]),
        .ramp_done_o (ch_done[g]),
        .power_ok_o  (ch_ok[g]),
        .ok_lost_o   (ch_lost[g]),
        .done_evt_o  (ch_done_evt[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // bus decode and next state
  logic              wr_en;
  logic              rd_en;
  logic [ADDR_W-1:0] ofs;
  logic [1:0]        ch_idx;
  logic              ch_hit;
  logic [IRQ_W-1:0]  evt;
  logic [IRQ_W-1:0]  clr;
  logic [31:0]       rd;
  logic              err;

  always_comb begin
    st_next = st_reg;
    // two-stage synchronisers; only stage 1 is read by logic
    st_next.en_sync   = {st_reg.en_sync[0], REGULATOR_ENABLE_PIN_I};
    st_next.pb_sync   = {st_reg.pb_sync[0], PUSHBUTTON_INPUT_N_I};
    st_next.sel_sync  = {st_reg.sel_sync[0], VOLTAGE_SET_SELECT_PIN_I};
    st_next.good_sync = {st_reg.good_sync[0], OUTPUT_GOOD_I};

    wr_en  = PSEL_I & PENABLE_I & PWRITE_I;
    rd_en  = PSEL_I & ~PENABLE_I & ~PWRITE_I;
    ofs    = PADDR_I & (CH_STRIDE - 12'h001);
    ch_idx = PADDR_I[5:4];
    ch_hit = (PADDR_I[ADDR_W-1:6] == '0) && (ch_idx < 2'(NUM_CH));
    rd     = 32'h0000_0000;
    err    = 1'b0;
    clr    = '0;

    if (PADDR_I[1:0] != 2'h0) begin
      err = 1'b1;
    end else if (ch_hit) begin
      case (ofs)
        OFS_CTRL: begin
          rd[BIT_ENABLE] = st_reg.en_bit[ch_idx];
          rd[BIT_RANGE]  = st_reg.range[ch_idx];
          if (wr_en && PSTRB_I[0]) begin
            // range and codes per channel, any order by hardware
            st_next.en_bit[ch_idx] = PWDATA_I[BIT_ENABLE];
            st_next.range[ch_idx]  = PWDATA_I[BIT_RANGE];
          end
        end
        OFS_PRIMARY: begin
          rd[CODE_W-1:0] = st_reg.prim[ch_idx];
          if (wr_en && PSTRB_I[0]) begin
            st_next.prim[ch_idx] = PWDATA_I[CODE_W-1:0];
          end
        end
        OFS_ALTERNATE: begin
          rd[CODE_W-1:0] = st_reg.alt[ch_idx];
          if (wr_en && PSTRB_I[0]) begin
            st_next.alt[ch_idx] = PWDATA_I[CODE_W-1:0];
          end
        end
        OFS_STATUS: begin
          rd[BIT_POWER_OK]  = ch_ok[ch_idx];
          rd[BIT_ACTIVE]    = ch_active[ch_idx];
          rd[BIT_RAMP_DONE] = ch_done[ch_idx];
        end
        default: err = 1'b1;
      endcase
    end else begin
      case (PADDR_I)
        OFS_IRQ_STATUS: begin
          rd[IRQ_W-1:0] = st_reg.irq_stat;
          if (wr_en && PSTRB_I[0]) begin
            clr = PWDATA_I[IRQ_W-1:0];
          end
        end
        OFS_IRQ_MASK: begin
          rd[IRQ_W-1:0] = st_reg.irq_mask;
          if (wr_en && PSTRB_I[0]) begin
            st_next.irq_mask = PWDATA_I[IRQ_W-1:0];
          end
        end
        OFS_PB_ASSIGN: begin
          rd[NUM_CH-1:0] = st_reg.pb_assign;
          if (wr_en && PSTRB_I[0]) begin
            st_next.pb_assign = PWDATA_I[NUM_CH-1:0];
          end
        end
        default: err = 1'b1;
      endcase
    end

    // read data captured in setup so it stands from the access cycle
    if (rd_en) begin
      st_next.rdata = rd;
    end
    st_next.slverr = PSEL_I & ~PENABLE_I & err;

    // sticky events: a new event beats a write-one clear in the same cycle
    evt = {ch_done_evt, ch_lost};
    st_next.irq_stat = (st_reg.irq_stat & ~clr) | evt;

    // one select for all channels; codes latched to output flops
    for (int i = 0; i < NUM_CH; i++) begin
      st_next.code_out[i] = st_reg.sel_sync[1] ? st_reg.alt[i] : st_reg.prim[i];
    end
    st_next.range_out = st_reg.range;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_reg           <= '0;
      st_reg.en_bit    <= {NUM_CH{DEFAULT_ENABLE}};
      st_reg.range     <= {NUM_CH{DEFAULT_RANGE}};
      st_reg.range_out <= {NUM_CH{DEFAULT_RANGE}};
      st_reg.prim      <= {NUM_CH{DEFAULT_CODE}};
      st_reg.alt       <= {NUM_CH{DEFAULT_CODE}};
      st_reg.code_out  <= {NUM_CH{DEFAULT_CODE}};
      st_reg.pb_assign <= DEFAULT_PB;
      st_reg.pb_sync   <= {SYNC_W{1'b1}};
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign PREADY_O           = 1'b1;
  assign PRDATA_O           = st_reg.rdata;
  assign PSLVERR_O          = st_reg.slverr & PSEL_I & PENABLE_I;
  assign CONVERTER_ENABLE_O = ch_active;
  assign VOLTAGE_RANGE_O    = st_reg.range_out;
  assign VOLTAGE_CODE_O     = st_reg.code_out;
  assign POWER_OK_O         = ch_ok;
  assign IRQ_O              = |(st_reg.irq_stat & st_reg.irq_mask);
endmodule

// ---- sim/bkreg_monitor.sv ----
// checker: port-level timing relations of the buck regulator control block
`timescale 1ns/1ps
module bkreg_monitor
  import bkreg_pkg::*;
#(
  parameter logic [RAMP_W-1:0] RAMP_CYC = RAMP_W'(SOFT_START_CYC)
) (
  input wire logic                                         CLK_I,
  input wire logic                                         RST_B_I,
  input wire logic                                         PSEL_I,
  input wire logic                                         PENABLE_I,
  input wire logic                                         PWRITE_I,
  input wire logic [bkreg_pkg::ADDR_W-1:0]                 PADDR_I,
  input wire logic                                         PREADY_O,
  input wire logic                                         PSLVERR_O,
  input wire logic [bkreg_pkg::NUM_CH-1:0]                 REGULATOR_ENABLE_PIN_I,
  input wire logic                                         PUSHBUTTON_INPUT_N_I,
  input wire logic                                         VOLTAGE_SET_SELECT_PIN_I,
  input wire logic [bkreg_pkg::NUM_CH-1:0]                 OUTPUT_GOOD_I,
  input wire logic [bkreg_pkg::NUM_CH-1:0]                 CONVERTER_ENABLE_O,
  input wire logic [bkreg_pkg::NUM_CH-1:0]                 VOLTAGE_RANGE_O,
  input wire logic [bkreg_pkg::NUM_CH*bkreg_pkg::CODE_W-1:0] VOLTAGE_CODE_O,
  input wire logic [bkreg_pkg::NUM_CH-1:0]                 POWER_OK_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  ////////////////////////////////////////////////////////////////////////////////
  // no bus write and a steady select pin: the voltage code must not wander
  sequence s_quiet;
    !(PSEL_I && PWRITE_I) && $stable(VOLTAGE_SET_SELECT_PIN_I);
  endsequence
  sequence s_access;
    PSEL_I && PENABLE_I;
  endsequence
  a_ready_high: assert property (s_access |-> PREADY_O) else $error("pready low");
  a_err_misalign: assert property (PSEL_I && PENABLE_I && PADDR_I[1:0] != 2'h0 |-> PSLVERR_O)
    else $error("misaligned access not refused");
  a_err_idle: assert property (!(PSEL_I && PENABLE_I) |-> !PSLVERR_O) else $error("stray error");
  a_code_stable: assert property (s_quiet [*4] |-> $stable(VOLTAGE_CODE_O)) else $error("code moved");
  a_range_stable: assert property (!(PSEL_I && PWRITE_I) [*3] |-> $stable(VOLTAGE_RANGE_O))
    else $error("range moved");
  a_ok_while_off: assert property ((POWER_OK_O & ~$past(CONVERTER_ENABLE_O)) == 3'h0)
    else $error("power ok while off");
  ////////////////////////////////////////////////////////////////////////////////
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    a_en_off: assert property ((!REGULATOR_ENABLE_PIN_I[c] && PUSHBUTTON_INPUT_N_I) [*4]
      |-> !CONVERTER_ENABLE_O[c]) else $error("channel on without cause");
    a_en_cause: assert property ($rose(CONVERTER_ENABLE_O[c])
      |-> $past(REGULATOR_ENABLE_PIN_I[c], 3) || !$past(PUSHBUTTON_INPUT_N_I, 3)) else $error("bad rise");
    a_ok_good: assert property (!OUTPUT_GOOD_I[c] [*3] |=> !POWER_OK_O[c]) else $error("ok kept");
  end
endmodule

bind bkreg_top bkreg_monitor #(.RAMP_CYC(RAMP_CYC)) u_mon (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .REGULATOR_ENABLE_PIN_I(REGULATOR_ENABLE_PIN_I),
  .PUSHBUTTON_INPUT_N_I(PUSHBUTTON_INPUT_N_I), .VOLTAGE_SET_SELECT_PIN_I(VOLTAGE_SET_SELECT_PIN_I),
  .OUTPUT_GOOD_I(OUTPUT_GOOD_I), .CONVERTER_ENABLE_O(CONVERTER_ENABLE_O),
  .VOLTAGE_RANGE_O(VOLTAGE_RANGE_O), .VOLTAGE_CODE_O(VOLTAGE_CODE_O), .POWER_OK_O(POWER_OK_O));

// ---- sim/bkreg_tb_top.sv ----
// testbench: register, pin and interrupt scenarios for the buck regulator control block
`timescale 1ns/1ps
module bkreg_tb_top;
  import bkreg_pkg::*;
  logic        clk, rst_b, psel, penable, pwrite, pb_n, voltage_set_select_pin, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  pin, good, en, rng, pok, rb;
  logic [17:0] code;
  logic [5:0]  pc[3], ac[3];
  logic [32:0] exp_q[$];
  int          errors, check_count;

  // short soft-start so the ramp fits the run
  bkreg_top #(.RAMP_CYC(14'd20)) i_dut (.CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .REGULATOR_ENABLE_PIN_I(pin),
    .PUSHBUTTON_INPUT_N_I(pb_n), .VOLTAGE_SET_SELECT_PIN_I(voltage_set_select_pin), .OUTPUT_GOOD_I(good),
    .CONVERTER_ENABLE_O(en), .VOLTAGE_RANGE_O(rng), .VOLTAGE_CODE_O(code), .POWER_OK_O(pok), .IRQ_O(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_bus(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
    cmp_bus({1'b0, got}, {1'b0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // expected {slverr, data} is noted at setup; the watcher below compares it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    exp_q.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask
  function automatic logic [11:0] ad(input int c, input logic [11:0] o);
    return CH_STRIDE * 12'(c) + o;
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      cmp_bus({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    cyc(5000);
    errors++;
    results();
  end
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, pin, good, voltage_set_select_pin} = '0;
    pb_n = 1'b1;
    void'($urandom(32'h766fcbaf));
    cyc(16);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int c = 0; c < 3; c++) begin
      rd(ad(c, OFS_CTRL), 32'h1);
      rd(ad(c, OFS_PRIMARY), {26'h0, DEFAULT_CODE});
      rd(ad(c, OFS_ALTERNATE), {26'h0, DEFAULT_CODE});
    end
    for (int s = 0; s < 2; s++) begin
      voltage_set_select_pin <= s[0];
      cyc(5);
      cmp_pin(32'(code), 32'({3{DEFAULT_CODE}}));
    end
    $display("test defaults done");
    for (int c = 0; c < 3; c++) begin
      {rb[c], pc[c], ac[c]} = 13'($urandom);
      // range goes in first, then the codes that live in it
      wr(ad(c, OFS_CTRL), {25'h0, rb[c], 6'h0});
      wr(ad(c, OFS_PRIMARY), {26'h0, pc[c]});
      wr(ad(c, OFS_ALTERNATE), {26'h0, ac[c]});
      wr(ad(c, OFS_STATUS), 32'hff);
    end
    for (int c = 0; c < 3; c++) begin
      rd(ad(c, OFS_CTRL), {25'h0, rb[c], 6'h0});
      rd(ad(c, OFS_PRIMARY), {26'h0, pc[c]});
      rd(ad(c, OFS_ALTERNATE), {26'h0, ac[c]});
      rd(ad(c, OFS_STATUS), 32'h0);
    end
    cmp_pin(32'(rng), 32'(rb));
    for (int s = 0; s < 2; s++) begin
      voltage_set_select_pin <= s[0];
      cyc(5);
      cmp_pin(32'(code), s ? 32'({ac[2], ac[1], ac[0]}) : 32'({pc[2], pc[1], pc[0]}));
    end
    $display("test setpoints done");
    good <= 3'h7;
    wr(OFS_IRQ_MASK, 32'h3f);
    wr(ad(0, OFS_CTRL), {25'h0, rb[0], 6'h1});
    pin <= 3'h1;
    cyc(4);
    cmp_pin(32'(en), 32'h1);
    cmp_pin(32'(pok), 32'h0);
    // ramp of 20 cycles: ok must still be low in the first cycle that ramp done reads high
    cyc(19);
    cmp_pin(32'(pok), 32'h0);
    cyc(1);
    cmp_pin(32'(pok), 32'h1);
    rd(ad(0, OFS_STATUS), 32'h7);
    cmp_pin(32'(irq), 32'h1);
    good <= 3'h6;
    cyc(5);
    cmp_pin(32'(pok), 32'h0);
    rd(OFS_IRQ_STATUS, 32'h9);
    wr(OFS_IRQ_MASK, 32'h0);
    cyc(2);
    cmp_pin(32'(irq), 32'h0);
    wr(OFS_IRQ_STATUS, 32'h3f);
    rd(OFS_IRQ_STATUS, 32'h0);
    wr(ad(0, OFS_CTRL), {25'h0, rb[0], 6'h0});
    cyc(3);
    cmp_pin(32'(en), 32'h0);
    $display("test enable_ramp_irq done");
    pin <= 3'h0;
    wr(OFS_PB_ASSIGN, 32'h4);
    rd(OFS_PB_ASSIGN, 32'h4);
    pb_n <= 1'b0;
    cyc(5);
    cmp_pin(32'(en), 32'h4);
    pb_n <= 1'b1;
    cyc(5);
    cmp_pin(32'(en), 32'h0);
    $display("test pushbutton done");
    apb(1'b0, 12'h050, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h002, 32'h5, {1'b1, 32'h0});
    $display("test refusals done");
    // every noted bus result must have been compared
    cmp_pin(32'(exp_q.size()), 32'h0);
    results();
  end
endmodule
